//--- rtl/data_transfer_defines.svh
`ifndef DATA_TRANSFER_DEFINES_SVH
`define DATA_TRANSFER_DEFINES_SVH
// instruction set shape
`define INSN_TYPE_COUNT    8'd55
`define INSN_GROUP_COUNT   4'd8
`define MOVE_TYPE_COUNT    2'd1
// register file
`define STACK_REG_INDEX    3'd7
`define GPR_RESET          16'h0000
// address forming
`define SHORT_ABS_PAGE     8'hff
`define STEP_BYTE          16'h0001
`define STEP_WORD          16'h0002
// command field widths
`define MODE_W             3
`endif

//--- rtl/data_transfer_pkg.sv
package data_transfer_pkg;
	// operand addressing modes of the move operation
	typedef enum logic [2:0] {
		AM_REG_DIRECT,
		AM_REG_INDIRECT,
		AM_DISP16,
		AM_ABS16,
		AM_ABS8,
		AM_IMM,
		AM_PREDEC,
		AM_POSTINC
	} addr_mode_t;
	// request kinds
	typedef enum logic [1:0] {
		OP_MOVE,
		OP_PUSH,
		OP_POP
	} op_kind_t;
	// execution states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_EXT,
		ST_MEM,
		ST_WAIT,
		ST_WB
	} exec_state_t;
endpackage

//--- rtl/move_mode_check.sv
`timescale 1ns/1ps
`include "data_transfer_defines.svh"
// legality of one move request
module move_mode_check (
	// request
	input  wire logic                          i_word,
	input  wire data_transfer_pkg::addr_mode_t i_mode,
	input  wire logic [2:0]                    i_areg,
	input  wire logic                          i_store,
	// verdict
	output logic                               o_legal
);
	always_comb begin
		o_legal = 1'b1;
		if (i_word && i_mode == data_transfer_pkg::AM_ABS8)
			o_legal = 1'b0;
		if (!i_word && (i_mode == data_transfer_pkg::AM_PREDEC || i_mode == data_transfer_pkg::AM_POSTINC)
		    && i_areg == `STACK_REG_INDEX)
			o_legal = 1'b0;
		if (i_mode == data_transfer_pkg::AM_IMM && i_store)
			o_legal = 1'b0;
		if (i_mode == data_transfer_pkg::AM_PREDEC && !i_store)
			o_legal = 1'b0;
		if (i_mode == data_transfer_pkg::AM_POSTINC && i_store)
			o_legal = 1'b0;
	end
endmodule

//--- rtl/data_transfer_unit.sv
`timescale 1ns/1ps
`include "data_transfer_defines.svh"
// Functional notes
// - instruction set has 55 types in eight groups; one general move type.
// - push is word store via stack predecrement; pop is word load postincrement.
// - moves register-register, register-memory, and immediate into register, byte or word.
// - word moves allow direct, indirect, disp16, abs16, imm16, predecrement, postincrement.
// - short absolute form is legal only for byte moves.
// - predecrement or postincrement on stack register needs word size.
// - address register steps by one for bytes, two for words, written back.
// - short absolute address uses all-ones upper byte.
// - odd word address has lowest bit forced to zero.
// - displacement mode fetches extension word and adds it to register.
module data_transfer_unit (
	// clock and reset
	input  wire logic                          i_mclk,
	input  wire logic                          i_rst_n,
	// command from the instruction sequencer
	input  wire logic                          i_cmd_valid,
	input  wire data_transfer_pkg::op_kind_t   i_cmd_op,
	input  wire logic                          i_cmd_word,
	input  wire logic                          i_cmd_store,
	input  wire data_transfer_pkg::addr_mode_t i_cmd_mode,
	input  wire logic [2:0]                    i_cmd_reg,
	input  wire logic [2:0]                    i_cmd_areg,
	input  wire logic [15:0]                   i_cmd_imm,
	// extension word supply
	input  wire logic                          i_ext_valid,
	input  wire logic [15:0]                   i_ext_data,
	// internal memory bus
	input  wire logic                          i_mem_ack,
	input  wire logic [15:0]                   i_mem_rdata,
	// status
	output logic                               o_busy,
	output logic                               o_done,
	output logic                               o_illegal,
	output logic                               o_ext_req,
	// memory request
	output logic                               o_mem_req,
	output logic                               o_mem_we,
	output logic                               o_mem_word,
	output logic [15:0]                        o_mem_addr,
	output logic [15:0]                        o_mem_wdata,
	// register file observation
	output logic [15:0]                        o_stack_pointer
);
	// latched command
	data_transfer_pkg::exec_state_t state, next_state;
	data_transfer_pkg::addr_mode_t  mode, next_mode;
	logic        word, next_word;
	logic        store, next_store;
	logic [2:0]  dreg, next_dreg;
	logic [2:0]  areg, next_areg;
	logic [15:0] opnd, next_opnd;
	logic [15:0] gpr [8];
	logic [15:0] next_gpr [8];
	logic        busy, next_busy;
	logic        done, next_done;
	logic        illegal, next_illegal;
	logic        ext_req, next_ext_req;
	logic        mem_req, next_mem_req;
	logic        mem_we, next_mem_we;
	logic        mem_word, next_mem_word;
	logic [15:0] mem_addr, next_mem_addr;
	logic [15:0] mem_wdata, next_mem_wdata;

	// effective command after push/pop aliasing
	data_transfer_pkg::addr_mode_t c_mode;
	logic        c_word;
	logic        c_store;
	logic [2:0]  c_areg;
	logic        c_legal;
	logic [15:0] step;
	logic [15:0] ea;

	// push and pop become word moves through the stack register
	always_comb begin
		c_mode  = i_cmd_mode;
		c_word  = i_cmd_word;
		c_store = i_cmd_store;
		c_areg  = i_cmd_areg;
		unique case (i_cmd_op)
			data_transfer_pkg::OP_PUSH: begin
				c_mode  = data_transfer_pkg::AM_PREDEC;
				c_word  = 1'b1;
				c_store = 1'b1;
				c_areg  = `STACK_REG_INDEX;
			end
			data_transfer_pkg::OP_POP: begin
				c_mode  = data_transfer_pkg::AM_POSTINC;
				c_word  = 1'b1;
				c_store = 1'b0;
				c_areg  = `STACK_REG_INDEX;
			end
			default: begin
				c_mode  = i_cmd_mode; // single general move type
			end
		endcase
	end

	// legality of size and mode pairing
	move_mode_check u_check (
		.i_word  (c_word),
		.i_mode  (c_mode),
		.i_areg  (c_areg),
		.i_store (c_store),
		.o_legal (c_legal)
	);

	// address step size
	assign step = word ? `STEP_WORD : `STEP_BYTE;

	// effective address before word alignment
	always_comb begin
		ea = gpr[areg];
		unique case (mode)
			data_transfer_pkg::AM_DISP16: ea = gpr[areg] + opnd;
			data_transfer_pkg::AM_ABS16:  ea = opnd;
			data_transfer_pkg::AM_ABS8:   ea = {`SHORT_ABS_PAGE, opnd[7:0]};
			data_transfer_pkg::AM_PREDEC: ea = gpr[areg] - step;
			default:                      ea = gpr[areg];
		endcase
	end

	// next-state computation
	always_comb begin
		next_state     = state;
		next_mode      = mode;
		next_word      = word;
		next_store     = store;
		next_dreg      = dreg;
		next_areg      = areg;
		next_opnd      = opnd;
		next_gpr       = gpr;
		next_busy      = busy;
		next_done      = 1'b0;
		next_illegal   = 1'b0;
		next_ext_req   = ext_req;
		next_mem_req   = mem_req;
		next_mem_we    = mem_we;
		next_mem_word  = mem_word;
		next_mem_addr  = mem_addr;
		next_mem_wdata = mem_wdata;
		unique case (state)
			data_transfer_pkg::ST_IDLE: begin
				if (i_cmd_valid) begin
					if (!c_legal) begin
						next_illegal = 1'b1;
						next_done    = 1'b1;
					end else begin
						next_mode  = c_mode;
						next_word  = c_word;
						next_store = c_store;
						next_dreg  = i_cmd_reg;
						next_areg  = c_areg;
						next_opnd  = i_cmd_imm;
						next_busy  = 1'b1;
						if (c_mode == data_transfer_pkg::AM_DISP16) begin
							next_ext_req = 1'b1;
							next_state   = data_transfer_pkg::ST_EXT;
						end else if (c_mode == data_transfer_pkg::AM_REG_DIRECT ||
						             c_mode == data_transfer_pkg::AM_IMM) begin
							next_state = data_transfer_pkg::ST_WB;
						end else begin
							next_state = data_transfer_pkg::ST_MEM;
						end
					end
				end
			end
			data_transfer_pkg::ST_EXT: begin
				if (i_ext_valid) begin
					next_opnd    = i_ext_data;
					next_ext_req = 1'b0;
					next_state   = data_transfer_pkg::ST_MEM;
				end
			end
			data_transfer_pkg::ST_MEM: begin
				next_mem_req   = 1'b1;
				next_mem_we    = store;
				next_mem_word  = word;
				next_mem_addr  = word ? {ea[15:1], 1'b0} : ea;
				next_mem_wdata = word ? gpr[dreg] : {8'h00, gpr[dreg][7:0]};
				if (mode == data_transfer_pkg::AM_PREDEC)
					next_gpr[areg] = ea;
				else if (mode == data_transfer_pkg::AM_POSTINC)
					next_gpr[areg] = gpr[areg] + step;
				next_state = data_transfer_pkg::ST_WAIT;
			end
			data_transfer_pkg::ST_WAIT: begin
				if (i_mem_ack) begin
					next_mem_req = 1'b0;
					next_mem_we  = 1'b0;
					next_opnd    = i_mem_rdata;
					next_state   = data_transfer_pkg::ST_WB;
				end
			end
			data_transfer_pkg::ST_WB: begin
				if (!store) begin
					if (mode == data_transfer_pkg::AM_REG_DIRECT) begin
						if (word)
							next_gpr[dreg] = gpr[areg];
						else
							next_gpr[dreg] = {gpr[dreg][15:8], gpr[areg][7:0]};
					end else if (word) begin
						next_gpr[dreg] = opnd;
					end else begin
						next_gpr[dreg] = {gpr[dreg][15:8], opnd[7:0]};
					end
				end else if (mode == data_transfer_pkg::AM_REG_DIRECT) begin
					if (word)
						next_gpr[areg] = gpr[dreg];
					else
						next_gpr[areg] = {gpr[areg][15:8], gpr[dreg][7:0]};
				end
				next_busy  = 1'b0;
				next_done  = 1'b1;
				next_state = data_transfer_pkg::ST_IDLE;
			end
			default: next_state = data_transfer_pkg::ST_IDLE;
		endcase
	end

	// state registers, all cleared by reset
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state     <= data_transfer_pkg::ST_IDLE;
			mode      <= data_transfer_pkg::AM_REG_DIRECT;
			word      <= 1'b0;
			store     <= 1'b0;
			dreg      <= 3'h0;
			areg      <= 3'h0;
			opnd      <= 16'h0000;
			for (int i = 0; i < 8; i++)
				gpr[i] <= `GPR_RESET;
			busy      <= 1'b0;
			done      <= 1'b0;
			illegal   <= 1'b0;
			ext_req   <= 1'b0;
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_word  <= 1'b0;
			mem_addr  <= 16'h0000;
			mem_wdata <= 16'h0000;
		end else begin
			state     <= next_state;
			mode      <= next_mode;
			word      <= next_word;
			store     <= next_store;
			dreg      <= next_dreg;
			areg      <= next_areg;
			opnd      <= next_opnd;
			gpr       <= next_gpr;
			busy      <= next_busy;
			done      <= next_done;
			illegal   <= next_illegal;
			ext_req   <= next_ext_req;
			mem_req   <= next_mem_req;
			mem_we    <= next_mem_we;
			mem_word  <= next_mem_word;
			mem_addr  <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
		end
	end

	// outputs straight from flip-flops
	assign o_busy          = busy;
	assign o_done          = done;
	assign o_illegal       = illegal;
	assign o_ext_req       = ext_req;
	assign o_mem_req       = mem_req;
	assign o_mem_we        = mem_we;
	assign o_mem_word      = mem_word;
	assign o_mem_addr      = mem_addr;
	assign o_mem_wdata     = mem_wdata;
	assign o_stack_pointer = gpr[`STACK_REG_INDEX];
endmodule

//--- dv/dt_props.sv
`timescale 1ns/1ps
module dt_props (
	// clock and reset
	input wire logic				i_mclk,
	input wire logic				i_rst_n,
	// command
	input wire logic				i_cmd_valid,
	input wire data_transfer_pkg::op_kind_t		i_cmd_op,
	input wire logic				i_cmd_word,
	input wire data_transfer_pkg::addr_mode_t	i_cmd_mode,
	input wire logic [2:0]				i_cmd_areg,
	input wire logic [15:0]				i_cmd_imm,
	input wire logic				i_mem_ack,
	// results
	input wire logic				o_busy,
	input wire logic				o_done,
	input wire logic				o_illegal,
	input wire logic				o_ext_req,
	input wire logic				o_mem_req,
	input wire logic				o_mem_word,
	input wire logic [15:0]				o_mem_addr,
	input wire logic [15:0]				o_stack_pointer
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	logic [15:0]	sp_take;
	logic [15:0]	imm_take;
	// pointer and immediate as seen at the take
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sp_take <= 16'h0000;
			imm_take <= 16'h0000;
		end else if (i_cmd_valid && !o_busy) begin
			sp_take <= o_stack_pointer;
			imm_take <= i_cmd_imm;
		end
	end
	sequence take_s;
		i_cmd_valid && !o_busy;
	endsequence
	sequence move_s;
		take_s ##0 i_cmd_op == data_transfer_pkg::OP_MOVE;
	endsequence
	illegal_with_done_a: assert property (o_illegal |-> o_done) else $error("refusal without done");
	word_short_a: assert property (move_s ##0 (i_cmd_word && i_cmd_mode == data_transfer_pkg::AM_ABS8)
		|-> ##[1:2] o_illegal) else $error("word short absolute accepted");
	stack_byte_a: assert property (move_s ##0 (!i_cmd_word && i_cmd_areg == 3'h7 &&
		(i_cmd_mode == data_transfer_pkg::AM_PREDEC || i_cmd_mode == data_transfer_pkg::AM_POSTINC))
		|-> ##[1:2] o_illegal) else $error("byte stack step accepted");
	push_addr_a: assert property (take_s ##0 i_cmd_op == data_transfer_pkg::OP_PUSH
		|-> ##[1:4] (o_mem_req && o_mem_word && o_mem_addr == sp_take - 16'h0002)) else $error("push address");
	pop_step_a: assert property (take_s ##0 i_cmd_op == data_transfer_pkg::OP_POP
		|-> ##[2:10] (o_done && o_stack_pointer == sp_take + 16'h0002)) else $error("pop pointer step");
	short_page_a: assert property (move_s ##0 (!i_cmd_word && i_cmd_mode == data_transfer_pkg::AM_ABS8)
		|-> ##[1:4] (o_mem_req && o_mem_addr == {8'hff, imm_take[7:0]})) else $error("short page address");
	word_even_a: assert property (o_mem_req && o_mem_word |-> !o_mem_addr[0]) else $error("odd word address");
	disp_ext_a: assert property (move_s ##0 i_cmd_mode == data_transfer_pkg::AM_DISP16
		|-> ##[1:2] o_ext_req) else $error("no extension request");
	req_hold_a: assert property (o_mem_req && !i_mem_ack
		|=> o_mem_req && $stable(o_mem_addr)) else $error("request moved");
	reset_idle_a: assert property ($rose(i_rst_n) |-> !o_busy && !o_mem_req) else $error("busy after reset");
endmodule

//--- dv/mem_model.sv
`timescale 1ns/1ps
module mem_model (
	// clock and reset
	input wire logic		i_mclk,
	input wire logic		i_rst_n,
	// request
	input wire logic		i_req,
	input wire logic		i_we,
	input wire logic		i_word,
	input wire logic [15:0]		i_addr,
	input wire logic [15:0]		i_wdata,
	// answer
	output logic			o_ack,
	output logic [15:0]		o_rdata
);
	logic [15:0]	mem [0:32767];
	logic [1:0]	wt;
	logic		slow;
	// answers alternate prompt and two cycles late; idle data toggles
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ack <= 1'b0;
			o_rdata <= 16'h0000;
			wt <= 2'h0;
			slow <= 1'b0;
		end else begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			if (i_req && !o_ack) begin
				if (wt == (slow ? 2'h2 : 2'h0)) begin
					o_ack <= 1'b1;
					wt <= 2'h0;
					slow <= !slow;
					if (i_we && i_word) mem[i_addr[15:1]] <= i_wdata;
					else if (i_we && i_addr[0]) mem[i_addr[15:1]][7:0] <= i_wdata[7:0];
					else if (i_we) mem[i_addr[15:1]][15:8] <= i_wdata[7:0];
					else if (i_word) o_rdata <= mem[i_addr[15:1]];
					else o_rdata <= {8'h00, i_addr[0] ? mem[i_addr[15:1]][7:0] : mem[i_addr[15:1]][15:8]};
				end else begin
					wt <= wt + 2'h1;
				end
			end
		end
	end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	logic				i_mclk, i_rst_n, i_cmd_valid, i_cmd_word, i_cmd_store, i_ext_valid, i_mem_ack;
	data_transfer_pkg::op_kind_t	i_cmd_op;
	data_transfer_pkg::addr_mode_t	i_cmd_mode;
	logic [2:0]			i_cmd_reg, i_cmd_areg;
	logic [15:0]			i_cmd_imm, i_ext_data, i_mem_rdata, o_mem_addr, o_mem_wdata, o_stack_pointer;
	logic				o_busy, o_done, o_illegal, o_ext_req, o_mem_req, o_mem_we, o_mem_word, ill;
	int				miscompares, tests_run;
	data_transfer_unit u_data_transfer_unit (.i_mclk, .i_rst_n, .i_cmd_valid, .i_cmd_op, .i_cmd_word,
		.i_cmd_store, .i_cmd_mode, .i_cmd_reg, .i_cmd_areg, .i_cmd_imm, .i_ext_valid, .i_ext_data, .i_mem_ack,
		.i_mem_rdata, .o_busy, .o_done, .o_illegal, .o_ext_req, .o_mem_req, .o_mem_we, .o_mem_word,
		.o_mem_addr, .o_mem_wdata, .o_stack_pointer);
	mem_model u_mem_model (.i_mclk, .i_rst_n, .i_req(o_mem_req), .i_we(o_mem_we), .i_word(o_mem_word),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
	// clock
	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	// displacement supply, one pulse per request
	always @(posedge i_mclk) begin
		i_ext_valid <= i_rst_n && o_ext_req && !i_ext_valid;
	end
	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [15:0] w16(input logic [15:0] ad);
		return u_mem_model.mem[ad[15:1]];
	endfunction
	task automatic run(input data_transfer_pkg::op_kind_t op, input logic w, input logic s,
		input data_transfer_pkg::addr_mode_t md, input logic [2:0] r, input logic [2:0] a, input logic [15:0] im);
		int n;
		@(posedge i_mclk);
		i_cmd_valid <= 1'b1;
		i_cmd_op <= op;
		i_cmd_word <= w;
		i_cmd_store <= s;
		i_cmd_mode <= md;
		i_cmd_reg <= r;
		i_cmd_areg <= a;
		i_cmd_imm <= im;
		@(posedge i_mclk);
		i_cmd_valid <= 1'b0;
		for (n = 0; n < 40; n++) begin
			@(negedge i_mclk);
			if (o_done === 1'b1) break;
		end
		if (n == 40) begin
			miscompares++;
			give_verdict();
		end
		ill = o_illegal;
	endtask
	task automatic mv(input logic w, input logic s, input data_transfer_pkg::addr_mode_t md,
		input logic [2:0] r, input logic [2:0] a, input logic [15:0] im);
		run(data_transfer_pkg::OP_MOVE, w, s, md, r, a, im);
	endtask
	task t_stack;
		mv(1'b1, 1'b0, data_transfer_pkg::AM_IMM, 3'h7, 3'h0, 16'h0100);
		chk("sp load", o_stack_pointer, 16'h0100);
		mv(1'b1, 1'b0, data_transfer_pkg::AM_IMM, 3'h1, 3'h0, 16'ha5c3);
		run(data_transfer_pkg::OP_PUSH, 1'b1, 1'b1, data_transfer_pkg::AM_PREDEC, 3'h1, 3'h7, 16'h0000);
		chk("push sp", o_stack_pointer, 16'h00fe);
		chk("push data", w16(16'h00fe), 16'ha5c3);
		run(data_transfer_pkg::OP_POP, 1'b1, 1'b0, data_transfer_pkg::AM_POSTINC, 3'h2, 3'h7, 16'h0000);
		chk("pop sp", o_stack_pointer, 16'h0100);
		mv(1'b1, 1'b1, data_transfer_pkg::AM_ABS16, 3'h2, 3'h0, 16'h0200);
		chk("pop data", w16(16'h0200), 16'ha5c3);
		$display("test stack finished");
	endtask
	task t_refuse;
		mv(1'b1, 1'b1, data_transfer_pkg::AM_ABS8, 3'h1, 3'h0, 16'h0034);
		chk("word short", {15'h0000, ill}, 16'h0001);
		mv(1'b0, 1'b1, data_transfer_pkg::AM_PREDEC, 3'h1, 3'h7, 16'h0000);
		chk("byte predec", {15'h0000, ill}, 16'h0001);
		mv(1'b0, 1'b0, data_transfer_pkg::AM_POSTINC, 3'h1, 3'h7, 16'h0000);
		chk("byte postinc", {15'h0000, ill}, 16'h0001);
		chk("sp kept", o_stack_pointer, 16'h0100);
		$display("test refuse finished");
	endtask
	task t_addr;
		mv(1'b0, 1'b1, data_transfer_pkg::AM_ABS8, 3'h1, 3'h0, 16'h0034);
		chk("short page", w16(16'hff34) >> 8, 16'h00c3);
		mv(1'b1, 1'b1, data_transfer_pkg::AM_ABS16, 3'h1, 3'h0, 16'h0301);
		chk("odd word", w16(16'h0300), 16'ha5c3);
		mv(1'b1, 1'b0, data_transfer_pkg::AM_IMM, 3'h3, 3'h0, 16'h0400);
		mv(1'b1, 1'b1, data_transfer_pkg::AM_REG_INDIRECT, 3'h1, 3'h3, 16'h0000);
		chk("indirect", w16(16'h0400), 16'ha5c3);
		mv(1'b1, 1'b1, data_transfer_pkg::AM_DISP16, 3'h1, 3'h3, 16'h0000);
		chk("displaced", w16(16'h0410), 16'ha5c3);
		mv(1'b0, 1'b0, data_transfer_pkg::AM_POSTINC, 3'h4, 3'h3, 16'h0000);
		mv(1'b1, 1'b1, data_transfer_pkg::AM_ABS16, 3'h3, 3'h0, 16'h0500);
		chk("byte step", w16(16'h0500), 16'h0401);
		mv(1'b1, 1'b1, data_transfer_pkg::AM_ABS16, 3'h4, 3'h0, 16'h0700);
		chk("byte load", w16(16'h0700), 16'h00a5);
		mv(1'b1, 1'b1, data_transfer_pkg::AM_REG_DIRECT, 3'h1, 3'h5, 16'h0000);
		mv(1'b1, 1'b1, data_transfer_pkg::AM_ABS16, 3'h5, 3'h0, 16'h0600);
		chk("reg move", w16(16'h0600), 16'ha5c3);
		mv(1'b1, 1'b0, data_transfer_pkg::AM_ABS16, 3'h7, 3'h0, 16'h0600);
		chk("word load", o_stack_pointer, 16'ha5c3);
		$display("test addressing finished");
	endtask
	task t_reset;
		@(posedge i_mclk);
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		@(negedge i_mclk);
		chk("reset sp", o_stack_pointer, 16'h0000);
		chk("reset busy", {15'h0000, o_busy}, 16'h0000);
		$display("test reset finished");
	endtask
	// main sequence
	initial begin
		i_rst_n = 1'b0;
		i_cmd_valid = 1'b0;
		i_cmd_op = data_transfer_pkg::OP_MOVE;
		i_cmd_word = 1'b0;
		i_cmd_store = 1'b0;
		i_cmd_mode = data_transfer_pkg::AM_REG_DIRECT;
		i_cmd_reg = 3'h0;
		i_cmd_areg = 3'h0;
		i_cmd_imm = 16'h0000;
		i_ext_data = 16'h0010;
		repeat (5) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_stack;
		t_refuse;
		t_addr;
		t_reset;
		give_verdict;
	end
endmodule
bind data_transfer_unit dt_props u_dt_props (.i_mclk, .i_rst_n, .i_cmd_valid, .i_cmd_op, .i_cmd_word,
	.i_cmd_mode, .i_cmd_areg, .i_cmd_imm, .i_mem_ack, .o_busy, .o_done, .o_illegal, .o_ext_req,
	.o_mem_req, .o_mem_word, .o_mem_addr, .o_stack_pointer);
